// >>> common/cam_prot_pkg.sv
/*
 * Shared constants and types for the two-wire target block of the camera
 * power protector: timing, address layout, decoder states and carriers.
 * Assumes a 125 MHz system clock; nothing else.
 */
package cam_prot_pkg;

    // system clock period and spike width
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SPIKE_NS = 50;
    // a pulse must outlast the spike width, so round up
    localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // 7-bit address: fixed upper four bits, two factory bits, strap bit
    localparam logic [3:0] ADDR_FIXED_HI = 4'h5;
    localparam logic [1:0] ADDR_OPT_DEFAULT = 2'h0;
    localparam logic [7:0] GENERAL_CALL = 8'h00;

    // bit counter value after a whole byte
    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_LAST_TX = 4'h7;

    // status registers whose read releases the latched fault
    localparam logic [7:0] STAT_FIRST = 8'h03;
    localparam logic [7:0] STAT_LAST = 8'h05;

    localparam int NUM_CH_DEFAULT = 4;

    // pin positions in the synchroniser vector
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_ADDR = 2;
    localparam int PIN_EN = 3;
    localparam int PIN_COUNT = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TXACK,
        ST_IGNORE
    } busState_t;

    typedef enum logic [1:0] {
        BY_ADDR,
        BY_REG,
        BY_DATA
    } byteKind_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } busEvt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } regReq_t;

endpackage

// >>> core/cam_prot_i2c_target.sv
/*
 * Two-wire serial target of the camera power protector, with enable-pin
 * edge handling and the open-drain fault output.
 * Assumes: pins arrive asynchronous to sys_clk and are synchronised here;
 * the register file sits outside, answers rdData in the same clock domain
 * and holds it stable until the next read strobe; faultPresent is the
 * already masked fault level from the fault logic.
 */
//
// Overview of operation
// - one data bit per clock period; data stable while clock high.
// - data change while clock high is a bus condition, never a bit.
// - data falling with clock high starts a transfer; address follows.
// - data rising with clock high ends the transfer; return to idle.
// - repeated start keeps bus busy; next byte is a fresh address.
// - stop honoured at any bit, except in the same high as a start.
// - clock line is input only; never stretched or driven.
// - all-zero address byte is never acknowledged.
// - first byte is 7-bit address then direction bit, one means read.
// - lowest address bit follows the address-select pin.
// - address bits two and one are factory options, default zero.
// - every byte is eight bits plus one acknowledge pulse.
// - acknowledge holds data low across the whole ninth clock high.
// - data line is open drain: pull low or release, sample released.
// - clock rates up to 1 MHz from the controller are served.
// - both lines idle high; bus free until a start is seen.
// - glitches shorter than about 50 ns are filtered out.
// - enable rising soft-starts enabled channels; falling turns all off.
// - fault output is active low, open drain.
// - write: start, address write, register byte, data byte, stop.
// - read: write address, register byte, repeated start, read, stop.
// - fault output asserts on unmasked fault, held until status read.
// - channel on only while enable pin and its config bit are high.
`timescale 1ns/1ps
`default_nettype none

module cam_prot_i2c_target #(
    parameter int NUM_CH = cam_prot_pkg::NUM_CH_DEFAULT,
    parameter logic [1:0] ADDR_OPT = cam_prot_pkg::ADDR_OPT_DEFAULT,
    parameter int FILT_CYC = cam_prot_pkg::SPIKE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrSelPin,
    input wire logic enPin,
    input wire logic [7:0] rdData,
    input wire logic [NUM_CH-1:0] chanEnCfg,
    input wire logic faultPresent,
    output cam_prot_pkg::regReq_t regReq,
    output logic [NUM_CH-1:0] chanOn,
    output logic [NUM_CH-1:0] softStart,
    output logic intOut,
    output logic intOe
);
    import cam_prot_pkg::*;

    localparam int FCW = $clog2(FILT_CYC + 1);

    generate
        if (NUM_CH < 1 || NUM_CH > 8 || FILT_CYC < 1) begin : gParamCheck
            $error("unsupported channel count or filter length");
        end
    endgenerate

    logic [PIN_COUNT-1:0] sync1_q;
    logic [PIN_COUNT-1:0] sync2_q;
    logic [1:0] filt_q;
    logic [1:0] filtPrev_q;
    logic sclF;
    logic sdaF;
    busEvt_t evt;
    busState_t state_q;
    byteKind_t kind_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] txShift_q;
    logic readDir_q;
    logic ackSeen_q;
    logic startHigh_q;
    logic sdaOe_q;
    regReq_t regReq_q;
    logic [6:0] ownAddr;
    logic faultLatch_q;
    logic faultLatch_d;
    logic intOe_q;
    logic enPrev_q;
    logic [NUM_CH-1:0] chanOn_q;
    logic [NUM_CH-1:0] softStart_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_q <= '1;
            sync2_q <= '1;
            // enable rests low on its pull-down; stages reset high would fake a rising edge
            sync1_q[PIN_EN] <= 1'b0;
            sync2_q[PIN_EN] <= 1'b0;
        end else begin
            sync1_q <= {enPin, addrSelPin, sdaIn, sclIn};
            sync2_q <= sync1_q;
        end
    end

    // a line only changes after staying put for FILT_CYC cycles; both lines
    // see the same delay so the data-after-clock ordering is preserved
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gFilt
            logic [FCW-1:0] cnt_q;
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    cnt_q <= '0;
                    filt_q[gi] <= 1'b1;
                end else if (sync2_q[gi] == filt_q[gi]) begin
                    cnt_q <= '0;
                end else if (cnt_q == FCW'(FILT_CYC - 1)) begin
                    cnt_q <= '0;
                    filt_q[gi] <= sync2_q[gi];
                end else begin
                    cnt_q <= cnt_q + FCW'(1);
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            filtPrev_q <= 2'h3;
        end else begin
            filtPrev_q <= filt_q;
        end
    end

    assign sclF = filt_q[PIN_SCL];
    assign sdaF = filt_q[PIN_SDA];

    // data moves while clock stays high: a condition, not a bit
    always_comb begin
        evt.rise = sclF & ~filtPrev_q[PIN_SCL];
        evt.fall = ~sclF & filtPrev_q[PIN_SCL];
        evt.start = sclF & filtPrev_q[PIN_SCL] & filtPrev_q[PIN_SDA] & ~sdaF;
        evt.stop = sclF & filtPrev_q[PIN_SCL] & ~filtPrev_q[PIN_SDA] & sdaF;
    end

    // strap bit is read live so a late-settling pin still counts
    assign ownAddr = {ADDR_FIXED_HI, ADDR_OPT, sync2_q[PIN_ADDR]};

    // a stop inside the same clock high as a start is not honoured
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            startHigh_q <= 1'b0;
        end else if (evt.start) begin
            startHigh_q <= 1'b1;
        end else if (evt.fall) begin
            startHigh_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            kind_q <= BY_ADDR;
            bitCnt_q <= '0;
            shift_q <= '0;
            txShift_q <= '0;
            readDir_q <= 1'b0;
            ackSeen_q <= 1'b0;
            sdaOe_q <= 1'b0;
            regReq_q <= '0;
        end else begin
            // strobes last one cycle; address holds until the next register byte, data until the next data byte
            regReq_q.wr <= 1'b0;
            regReq_q.rd <= 1'b0;
            if (evt.start) begin
                state_q <= ST_RX;
                kind_q <= BY_ADDR;
                bitCnt_q <= '0;
                sdaOe_q <= 1'b0;
            end else if (evt.stop && !startHigh_q) begin
                state_q <= ST_IDLE;
                sdaOe_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        // free bus: nothing is driven until a start is seen
                        sdaOe_q <= 1'b0;
                    end
                    ST_RX: begin
                        if (evt.rise) begin
                            shift_q <= {shift_q[6:0], sdaF};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end else if (evt.fall && bitCnt_q == BIT_CNT_BYTE) begin
                            bitCnt_q <= '0;
                            case (kind_q)
                                BY_ADDR: begin
                                    if (shift_q != GENERAL_CALL && shift_q[7:1] == ownAddr) begin
                                        state_q <= ST_ACK;
                                        sdaOe_q <= 1'b1;
                                        readDir_q <= shift_q[0];
                                        kind_q <= BY_REG;
                                        // fetch early; data is loaded at the end of the ack
                                        regReq_q.rd <= shift_q[0];
                                    end else begin
                                        state_q <= ST_IGNORE;
                                    end
                                end
                                BY_REG: begin
                                    regReq_q.addr <= shift_q;
                                    kind_q <= BY_DATA;
                                    state_q <= ST_ACK;
                                    sdaOe_q <= 1'b1;
                                end
                                default: begin
                                    // extra data bytes rewrite the same register
                                    regReq_q.data <= shift_q;
                                    regReq_q.wr <= 1'b1;
                                    state_q <= ST_ACK;
                                    sdaOe_q <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        // ack released only after the ninth clock falls
                        if (evt.fall) begin
                            bitCnt_q <= '0;
                            if (readDir_q) begin
                                state_q <= ST_TX;
                                txShift_q <= rdData;
                                sdaOe_q <= ~rdData[7];
                            end else begin
                                state_q <= ST_RX;
                                sdaOe_q <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (evt.fall) begin
                            if (bitCnt_q == BIT_CNT_LAST_TX) begin
                                state_q <= ST_TXACK;
                                sdaOe_q <= 1'b0;
                            end else begin
                                bitCnt_q <= bitCnt_q + 4'h1;
                                txShift_q <= {txShift_q[6:0], 1'b0};
                                sdaOe_q <= ~txShift_q[6];
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (evt.rise) begin
                            ackSeen_q <= ~sdaF;
                            regReq_q.rd <= ~sdaF;
                        end else if (evt.fall) begin
                            bitCnt_q <= '0;
                            if (ackSeen_q) begin
                                state_q <= ST_TX;
                                txShift_q <= rdData;
                                sdaOe_q <= ~rdData[7];
                            end else begin
                                // a master nack ends the read; only a new start wakes us
                                state_q <= ST_IGNORE;
                            end
                        end
                    end
                    ST_IGNORE: begin
                        sdaOe_q <= 1'b0;
                    end
                    default: begin
                        sdaOe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // a new fault in the clearing cycle keeps the latch set
    always_comb begin
        faultLatch_d = faultLatch_q;
        if (regReq_q.rd && regReq_q.addr >= STAT_FIRST && regReq_q.addr <= STAT_LAST) begin
            faultLatch_d = 1'b0;
        end
        if (faultPresent) begin
            faultLatch_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            faultLatch_q <= 1'b0;
            intOe_q <= 1'b0;
        end else begin
            faultLatch_q <= faultLatch_d;
            intOe_q <= faultLatch_d;
        end
    end

    // last synchronised enable level, for the rising-edge soft-start
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enPrev_q <= 1'b0;
        end else begin
            enPrev_q <= sync2_q[PIN_EN];
        end
    end

    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : gChan
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    chanOn_q[gi] <= 1'b0;
                    softStart_q[gi] <= 1'b0;
                end else begin
                    chanOn_q[gi] <= sync2_q[PIN_EN] & chanEnCfg[gi];
                    softStart_q[gi] <= sync2_q[PIN_EN] & ~enPrev_q & chanEnCfg[gi];
                end
            end
        end
    endgenerate

    // no clock output exists: the clock line is never driven
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_q;
    assign intOut = 1'b0;
    assign intOe = intOe_q;
    assign regReq = regReq_q;
    assign chanOn = chanOn_q;
    assign softStart = softStart_q;

    // 1 MHz clock high of 260 ns is ~32 cycles, well above filter plus sync

endmodule

`default_nettype wire

// >>> verification/cam_prot_i2c_target_asserts.sv
/*
 * Concurrent checks on the two-wire target's pins and side outputs.
 * Sees only the top module's ports; bound in below.
 */
`timescale 1ns/1ps
`default_nettype none

module cam_prot_i2c_target_asserts
    import cam_prot_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic enPin,
    input wire logic [NUM_CH-1:0] chanEnCfg,
    input wire logic faultPresent,
    input wire cam_prot_pkg::regReq_t regReq,
    input wire logic [NUM_CH-1:0] chanOn,
    input wire logic [NUM_CH-1:0] softStart,
    input wire logic intOut,
    input wire logic intOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic clrHit;
    assign clrHit = regReq.rd && regReq.addr >= STAT_FIRST && regReq.addr <= STAT_LAST;

    sequence s_clr;
        clrHit && !faultPresent;
    endsequence
    sequence s_en_low;
        !enPin [*6];
    endsequence

    property p_od;
        sdaOut == 1'b0 && intOut == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("open-drain data low");
    // the pin path lag stays inside the clock low time
    property p_no_change_high;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    a_no_change_high: assert property (p_no_change_high) else $error("data moved, clk high");
    property p_soft_start;
        $rose(enPin) |-> ##[1:6] (softStart == chanEnCfg);
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft-start mismatch");
    property p_chan_gate;
        (chanOn & ~$past(chanEnCfg)) == '0;
    endproperty
    a_chan_gate: assert property (p_chan_gate) else $error("channel on without cfg");
    property p_chan_off;
        s_en_low |-> chanOn == '0;
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("channel on, enable low");
    property p_fault_set;
        faultPresent |=> intOe;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not signalled");
    property p_fault_hold;
        intOe && !clrHit |=> intOe;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped unread");
    property p_fault_clear;
        s_clr |=> !intOe;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
endmodule

bind cam_prot_i2c_target cam_prot_i2c_target_asserts #(.NUM_CH(NUM_CH)) chkInst (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .enPin(enPin), .chanEnCfg(chanEnCfg), .faultPresent(faultPresent), .regReq(regReq),
    .chanOn(chanOn), .softStart(softStart), .intOut(intOut), .intOe(intOe)
);
`default_nettype wire

// >>> verification/i2c_ctrl_model.sv
/*
 * Behavioural two-wire bus controller driving the target's pins.
 * Assumes a pull-up on data; moves pins at the system clock's falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module i2c_ctrl_model (
    input wire logic sys_clk,
    input wire logic sdaOe,
    output logic sclIn,
    output logic sdaIn
);
    logic sdaDrv = 1'b1;

    initial sclIn = 1'b1;
    assign sdaIn = sdaDrv & ~sdaOe;

    task automatic waitc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // low 7 cycles, high 3: 80 ns a bit; late sample hides the pin lag
    task automatic bitIo(input logic b, output logic r);
        sdaDrv = b;
        waitc(5);
        sclIn = 1'b1;
        waitc(2);
        r = sdaIn;
        waitc(1);
        sclIn = 1'b0;
        waitc(2);
    endtask
    task automatic start();
        sdaDrv = 1'b1;
        waitc(5);
        sclIn = 1'b1;
        waitc(4);
        sdaDrv = 1'b0;
        waitc(4);
        sclIn = 1'b0;
        waitc(2);
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        waitc(5);
        sclIn = 1'b1;
        waitc(4);
        sdaDrv = 1'b1;
        waitc(6);
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitIo(b[i], r);
        bitIo(1'b1, r);
        ack = ~r;
    endtask
    task automatic getByte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, r);
            b[i] = r;
        end
        bitIo(nack, r);
    endtask
    task automatic sclGlitch();
        waitc(2);
        sclIn = 1'b1;
        waitc(1);
        sclIn = 1'b0;
        waitc(2);
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
/*
 * Self-checking bench: random writes and reads, address sweep, early stop,
 * spike filter, enable and fault pins. Needs the controller model.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import cam_prot_pkg::*;

    logic sys_clk, rst_n, sclIn, sdaIn, sdaOut, sdaOe, addrSelPin, enPin;
    logic faultPresent, intOut, intOe, ack;
    logic [7:0] rdData, got, regA, dat, wrAddr, wrData;
    logic [3:0] chanEnCfg, chanOn, softStart, ssAcc;
    logic [6:0] dev;
    regReq_t regReq;
    int miscompares = 0;
    int checked = 0;
    int seed = 32'ha831;
    int cycles = 0;
    int wrCnt = 0;
    int expCnt;

    cam_prot_i2c_target #(.NUM_CH(4), .FILT_CYC(2)) cam_prot_i2c_target_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrSelPin(addrSelPin), .enPin(enPin), .rdData(rdData),
        .chanEnCfg(chanEnCfg), .faultPresent(faultPresent), .regReq(regReq),
        .chanOn(chanOn), .softStart(softStart), .intOut(intOut), .intOe(intOe)
    );
    i2c_ctrl_model i2c_ctrl_model_inst (
        .sys_clk(sys_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn)
    );

    function automatic logic [7:0] rdFn(input logic [7:0] a);
        return {a[3:0], a[7:4]} ^ 8'h3c;
    endfunction

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) rdData <= rdFn(regReq.addr);

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        ssAcc <= ssAcc | softStart;
        if (regReq.wr === 1'b1) begin
            wrCnt <= wrCnt + 1;
            wrAddr <= regReq.addr;
            wrData <= regReq.data;
        end
        if (cycles == 30000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        checked = checked + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic sendChk(input logic [7:0] b, input logic e);
        i2c_ctrl_model_inst.sendByte(b, ack);
        check({7'h0, ack}, {7'h0, e});
    endtask
    task automatic rdOne(input logic [7:0] r);
        i2c_ctrl_model_inst.start();
        sendChk({dev, 1'b0}, 1'b1);
        sendChk(r, 1'b1);
        i2c_ctrl_model_inst.start();
        sendChk({dev, 1'b1}, 1'b1);
        i2c_ctrl_model_inst.getByte(1'b1, got);
        i2c_ctrl_model_inst.stop();
        check(got, rdFn(r));
    endtask

    initial begin
        {rst_n, addrSelPin, enPin, faultPresent, chanEnCfg, ssAcc} = '0;
        dev = 7'h28;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (15) @(negedge sys_clk);
        for (int k = 0; k < 6; k++) begin
            addrSelPin = 1'($random(seed));
            dev = {6'h14, addrSelPin};
            regA = (k == 0) ? 8'hff : 8'($random(seed));
            dat = (k == 1) ? 8'h00 : 8'($random(seed));
            repeat (8) @(negedge sys_clk);
            expCnt = wrCnt + 1;
            i2c_ctrl_model_inst.start();
            sendChk({dev, 1'b0}, 1'b1);
            sendChk(regA, 1'b1);
            sendChk(dat, 1'b1);
            i2c_ctrl_model_inst.stop();
            check(8'(wrCnt), 8'(expCnt));
            check(wrAddr, regA);
            check(wrData, dat);
            rdOne(regA);
        end
        for (int a = 0; a < 18; a++) begin
            addrSelPin = (a >= 9);
            dev = {6'h14, addrSelPin};
            dat = (a % 9 < 8) ? 8'(8'h50 + 2 * (a % 9)) : 8'h00;
            repeat (8) @(negedge sys_clk);
            i2c_ctrl_model_inst.start();
            sendChk(dat, dat[7:1] == dev);
            if (dat[7:1] != dev) begin
                sendChk({dev, 1'b0}, 1'b0);
                i2c_ctrl_model_inst.stop();
                // after a missing ack the controller retries the address byte with its own address
                i2c_ctrl_model_inst.start();
                sendChk({dev, 1'b0}, 1'b1);
            end
            i2c_ctrl_model_inst.stop();
        end
        expCnt = wrCnt;
        i2c_ctrl_model_inst.start();
        sendChk({dev, 1'b0}, 1'b1);
        sendChk(8'h01, 1'b1);
        repeat (4) i2c_ctrl_model_inst.bitIo(1'b0, ack);
        i2c_ctrl_model_inst.stop();
        // clocking on without a start must not complete the cut data byte
        i2c_ctrl_model_inst.sclGlitch();
        repeat (5) i2c_ctrl_model_inst.bitIo(1'b0, ack);
        check(8'(wrCnt), 8'(expCnt));
        // a one-cycle clock spike must not shift the address by a bit
        i2c_ctrl_model_inst.start();
        i2c_ctrl_model_inst.sclGlitch();
        sendChk({dev, 1'b0}, 1'b1);
        i2c_ctrl_model_inst.stop();
        // mid-run reset with every channel configured: no false enable edge
        chanEnCfg = 4'hf;
        rst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        ssAcc = 4'h0;
        repeat (8) @(negedge sys_clk);
        check({4'h0, ssAcc}, 8'h00);
        check({4'h0, chanOn}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            chanEnCfg = 4'($random(seed));
            ssAcc = 4'h0;
            enPin = 1'b1;
            repeat (8) @(negedge sys_clk);
            check({4'h0, ssAcc}, {4'h0, chanEnCfg});
            chanEnCfg = ~chanEnCfg;
            ssAcc = 4'h0;
            repeat (4) @(negedge sys_clk);
            check({4'h0, chanOn}, {4'h0, chanEnCfg});
            check({4'h0, ssAcc}, 8'h00);
            enPin = 1'b0;
            repeat (8) @(negedge sys_clk);
            check({4'h0, chanOn}, 8'h00);
        end
        faultPresent = 1'b1;
        @(negedge sys_clk) faultPresent = 1'b0;
        repeat (30) @(negedge sys_clk);
        check({7'h0, intOe}, 8'h01);
        rdOne(8'h02);
        check({7'h0, intOe}, 8'h01);
        rdOne(8'h04);
        check({7'h0, intOe}, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
